// >>> rtl/spics_top.sv
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "spics_defs.svh"
// ----------------------------------------
// Serial port control and status block
// ----------------------------------------
module spics_top
    import spics_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic timer_two_pulse,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic sdo_i,
    output logic sdo_o,
    output logic sdo_oe,
    input wire logic sdi_i,
    output logic sdi_o,
    output logic sdi_oe,
    input wire logic ss_n_i,
    output logic ss_n_o,
    output logic ss_n_oe,
    output logic irq
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic spics_reg_e decode(input logic [ADDR_W-1:0] a);
        logic [7:0] o;
        o = 8'(a);
        unique case (o)
            `SPICS_CTRL_OFS: decode = SPICS_R_CTRL;
            `SPICS_BUF_OFS: decode = SPICS_R_BUF;
            `SPICS_STAT_OFS: decode = SPICS_R_STAT;
            `SPICS_CLR_OFS: decode = SPICS_R_CLR;
            `SPICS_IEN_OFS: decode = SPICS_R_IEN;
            `SPICS_GPIO_OFS: decode = SPICS_R_GPIO;
            default: decode = SPICS_R_NONE;
        endcase
    endfunction

    // Master modes drive the serial clock
    function automatic logic is_master(input spics_mode_t m);
        is_master = (m == `SPICS_MODE_M16) || (m == `SPICS_MODE_M64)
            || (m == `SPICS_MODE_MTMR);
    endfunction

    // Slave modes take the clock from the pin
    function automatic logic is_slave(input spics_mode_t m);
        is_slave = (m == `SPICS_MODE_SSS) || (m == `SPICS_MODE_SNOSS);
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic aw_held, w_held; // Write halves captured
    logic [ADDR_W-1:0] aw_addr; // Held write address
    logic [7:0] w_data; // Held write data, low lane
    logic w_lane0; // Low byte lane enabled
    logic wr_fire; // Both halves present
    spics_reg_e wr_reg, rd_reg; // Decoded targets
    logic wr_ctrl, wr_buf, wr_clr, wr_ien, wr_gpio;
    logic rd_buf; // Buffer read, frees it
    logic [31:0] next_rdata; // Read mux result

    logic port_en, clock_idle_polarity; // Enable and idle level
    spics_mode_t mode; // Mode field
    logic write_collision_flag, ovf; // Sticky control flags
    logic [7:0] rx_buf; // Transfer buffer, read side
    logic buf_full; // Unread byte present
    logic [2:0] irq_stat, irq_en; // Interrupt status, mask
    logic [3:0] gpio_out, gpio_oe; // GPIO drive when free

    logic [3:0] pin_m, pin_s; // Pin synchroniser stages
    logic sck_s, sdi_s, ss_n_s; // Synchronised pin levels
    logic sck_d; // Previous clock pin level

    logic master, slave, selected; // Current role
    logic xfer_active; // Master byte running
    logic [4:0] div_cnt; // Oscillator divider
    logic [4:0] half_last; // Divider end count
    logic tick; // Half-period enable
    logic sck_phase; // Master clock away from idle
    logic lead, trail; // Slave clock edges
    logic run, sample_en, shift_en;
    logic busy, load, coll, done, ovf_evt;
    logic sdo_bit;
    logic [7:0] rx_byte;
    logic mid_busy; // Slave byte under way

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign wr_fire = aw_held && w_held && !bvalid;
    assign wr_reg = decode(aw_addr);

    // Address and data are taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 8'h00;
            w_lane0 <= 1'b0;
        end
        else if (wr_fire)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_held <= 1'b1;
                w_data <= wdata[7:0];
                w_lane0 <= wstrb[0];
            end
        end
    end

    // Response one cycle after both halves meet
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp <= 2'b00;
        end
        else if (wr_fire)
        begin
            bvalid <= 1'b1;
            // Unmapped address answers SLVERR
            bresp <= (wr_reg == SPICS_R_NONE) ? 2'b10 : 2'b00;
        end
        else if (bready)
            bvalid <= 1'b0;
    end

    // Strobes; other byte lanes hold nothing
    assign wr_ctrl = wr_fire && w_lane0 && (wr_reg == SPICS_R_CTRL);
    assign wr_buf = wr_fire && w_lane0 && (wr_reg == SPICS_R_BUF);
    assign wr_clr = wr_fire && w_lane0 && (wr_reg == SPICS_R_CLR);
    assign wr_ien = wr_fire && w_lane0 && (wr_reg == SPICS_R_IEN);
    assign wr_gpio = wr_fire && w_lane0 && (wr_reg == SPICS_R_GPIO);

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    assign arready = !rvalid;
    assign rd_reg = decode(araddr);
    assign rd_buf = arvalid && arready && (rd_reg == SPICS_R_BUF);

    // Read mux; clear register reads as zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (rd_reg)
            SPICS_R_CTRL: next_rdata[7:0] = {write_collision_flag, ovf, port_en, clock_idle_polarity, mode};
            SPICS_R_BUF: next_rdata[7:0] = rx_buf;
            SPICS_R_STAT: next_rdata[2:0] = irq_stat;
            SPICS_R_IEN: next_rdata[2:0] = irq_en;
            SPICS_R_GPIO: next_rdata[11:0] = {pin_s, gpio_oe, gpio_out};
            SPICS_R_CLR, SPICS_R_NONE: next_rdata = 32'h0000_0000;
        endcase
    end

    // Data registered on acceptance, held until taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'b00;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= (rd_reg == SPICS_R_NONE) ? 2'b10 : 2'b00;
        end
        else if (rready)
            rvalid <= 1'b0;
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            {port_en, clock_idle_polarity, mode} <= 6'(`SPICS_CTRL_RST);
        else if (wr_ctrl)
        begin
            port_en <= w_data[`SPICS_EN_BIT];
            clock_idle_polarity <= w_data[`SPICS_CKP_BIT];
            mode <= w_data[3:0];
        end
    end

    // Collision flag: writing zero clears, event wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            write_collision_flag <= 1'b0;
        else if (coll)
            write_collision_flag <= 1'b1;
        else if (wr_ctrl && !w_data[`SPICS_WRITE_COLLISION_FLAG_BIT])
            write_collision_flag <= 1'b0;
    end

    // Overflow flag, slave only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ovf <= 1'b0;
        else if (ovf_evt)
            ovf <= 1'b1;
        else if (wr_ctrl && !w_data[`SPICS_OVF_BIT])
            ovf <= 1'b0;
    end

    // ----------------------------------------
    // Transfer buffer
    // ----------------------------------------
    // Host must read each slave byte to avoid overflow
    // A read in the same cycle frees the buffer in time
    assign ovf_evt = done && buf_full && !rd_buf && slave;
    assign busy = master ? xfer_active : run && mid_busy;
    assign coll = wr_buf && port_en && busy;
    assign load = wr_buf && port_en && !busy;

    // Receive side; an overflowed byte never lands
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_buf <= 8'h00;
            buf_full <= 1'b0;
        end
        else if (done && !ovf_evt)
        begin
            rx_buf <= rx_byte;
            buf_full <= 1'b1;
        end
        else if (rd_buf)
            buf_full <= 1'b0;
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    // Sticky status, write-one clear, set wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_stat <= 3'h0;
        else
            irq_stat <= (irq_stat & ~(wr_clr ? w_data[2:0] : 3'h0))
                | {ovf_evt, coll, done};
    end

    // Enable mask and GPIO drive
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_en <= 3'h0;
            {gpio_oe, gpio_out} <= `SPICS_GPIO_RST;
        end
        else
        begin
            if (wr_ien)
                irq_en <= w_data[2:0];
            if (wr_gpio)
                {gpio_oe, gpio_out} <= w_data;
        end
    end

    assign irq = |(irq_stat & irq_en);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Only the second stage feeds any logic
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_m <= 4'h0;
            pin_s <= 4'h0;
        end
        else
        begin
            pin_m <= {ss_n_i, sdi_i, sdo_i, sck_i};
            pin_s <= pin_m;
        end
    end

    assign sck_s = pin_s[0];
    assign sdi_s = pin_s[2];
    assign ss_n_s = pin_s[3];

    // ----------------------------------------
    // Role and master clock generation
    // ----------------------------------------
    assign master = port_en && is_master(mode);
    assign slave = port_en && is_slave(mode);
    // Select pin gates mode 0100 only
    assign selected = (mode == `SPICS_MODE_SNOSS) || !ss_n_s;

    // Master byte runs from buffer write to last edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !master)
            xfer_active <= 1'b0;
        else if (load)
            xfer_active <= 1'b1;
        else if (done)
            xfer_active <= 1'b0;
    end

    // Half period in oscillator cycles
    assign half_last = (mode == `SPICS_MODE_M64) ? 5'((`SPICS_DIV64 / 2) - 1)
        : 5'((`SPICS_DIV16 / 2) - 1);

    // Divider restarts with each byte
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !xfer_active || tick)
            div_cnt <= 5'd0;
        else
            div_cnt <= div_cnt + 5'd1;
    end

    // Timer pulse halves directly, since each toggles the clock
    assign tick = xfer_active && ((mode == `SPICS_MODE_MTMR) ? timer_two_pulse
        : (div_cnt == half_last));

    // Clock phase; back at idle whenever no byte runs
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !xfer_active)
            sck_phase <= 1'b0;
        else if (tick)
            sck_phase <= !sck_phase;
    end

    // ----------------------------------------
    // Slave clock edges
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sck_d <= 1'b0;
        else
            sck_d <= sck_s;
    end

    // Leading edge leaves the idle level set by polarity
    assign lead = (sck_d == clock_idle_polarity) && (sck_s != clock_idle_polarity);
    assign trail = (sck_d != clock_idle_polarity) && (sck_s == clock_idle_polarity);

    // ----------------------------------------
    // Shift engine
    // ----------------------------------------
    assign run = master ? xfer_active : slave && selected;
    assign sample_en = master ? tick && !sck_phase : lead;
    assign shift_en = master ? tick && sck_phase : trail;

    spics_shift spics_shift_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run),
        .load(load),
        .load_data(w_data),
        .sample_en(sample_en),
        .shift_en(shift_en),
        .sdi(sdi_s),
        .sdo(sdo_bit),
        .mid_byte(mid_busy),
        .done(done),
        .rx_byte(rx_byte)
    );

    // ----------------------------------------
    // Pin takeover
    // ----------------------------------------
    always_comb
    begin
        if (port_en)
        begin
            // Serial pins owned by the port
            sck_o = clock_idle_polarity ^ sck_phase;
            sck_oe = master;
            sdo_o = sdo_bit;
            sdo_oe = master || (slave && selected);
            sdi_o = 1'b0;
            sdi_oe = 1'b0;
            // Select pin stays general purpose in 0101
            ss_n_o = (mode == `SPICS_MODE_SNOSS) ? gpio_out[3] : 1'b0;
            ss_n_oe = (mode == `SPICS_MODE_SNOSS) ? gpio_oe[3] : 1'b0;
        end
        else
        begin
            // All four pins back to GPIO
            {ss_n_o, sdi_o, sdo_o, sck_o} = gpio_out;
            {ss_n_oe, sdi_oe, sdo_oe, sck_oe} = gpio_oe;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    write_collision_flag_set_a: assert property (coll |=> write_collision_flag)
        else $error("collision did not set flag");
    ovf_set_a: assert property (done && buf_full && !rd_buf && slave |=> ovf)
        else $error("slave overflow did not set flag");
    ovf_keep_a: assert property (ovf_evt |=> $stable(rx_buf) && buf_full)
        else $error("overflow overwrote buffer");
    ovf_master_a: assert property ($rose(ovf) |-> $past(slave))
        else $error("overflow raised outside slave mode");
    pin_take_a: assert property (master |-> sck_oe && sdo_oe && !sdi_oe)
        else $error("master pins not taken");
    pin_free_a: assert property (!port_en |-> sck_oe == gpio_oe[0]
        && sdo_o == gpio_out[1] && ss_n_oe == gpio_oe[3])
        else $error("disabled port kept pins");
    idle_pol_a: assert property (master && !xfer_active |-> sck_o == clock_idle_polarity)
        else $error("clock not at idle level");
    ss_free_a: assert property (slave && mode == `SPICS_MODE_SNOSS && ss_n_s
        |-> run && ss_n_oe == gpio_oe[3])
        else $error("select pin not ignored");
    div16_a: assert property (tick && mode == `SPICS_MODE_M16 && !done
        |=> (!tick)[*7] ##1 tick)
        else $error("divide by 16 spacing wrong");
    tmr_div_a: assert property (xfer_active && mode == `SPICS_MODE_MTMR && timer_two_pulse
        && !wr_ctrl |=> sck_o != $past(sck_o))
        else $error("timer pulse not driving clock");
    ss_gate_a: assert property (slave && mode == `SPICS_MODE_SSS && ss_n_s |-> !run
        && !sdo_oe)
        else $error("deselected slave still active");

    master_byte_c: cover property (master && done);
    slave_ovf_c: cover property (ovf_evt);
    collision_c: cover property (coll);
    irq_c: cover property ($rose(irq));

endmodule
`default_nettype wire

// >>> rtl/spics_defs.svh
`ifndef SPICS_DEFS_SVH
`define SPICS_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SPICS_CTRL_OFS 8'h00
`define SPICS_BUF_OFS 8'h04
`define SPICS_STAT_OFS 8'h08
`define SPICS_CLR_OFS 8'h0c
`define SPICS_IEN_OFS 8'h10
`define SPICS_GPIO_OFS 8'h14

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define SPICS_WRITE_COLLISION_FLAG_BIT 7
`define SPICS_OVF_BIT 6
`define SPICS_EN_BIT 5
`define SPICS_CKP_BIT 4
`define SPICS_CTRL_RST 8'h00
`define SPICS_GPIO_RST 8'h00

// ----------------------------------------
// Mode field encodings
// ----------------------------------------
`define SPICS_MODE_M16 4'h1
`define SPICS_MODE_M64 4'h2
`define SPICS_MODE_MTMR 4'h3
`define SPICS_MODE_SSS 4'h4
`define SPICS_MODE_SNOSS 4'h5

// ----------------------------------------
// Clock division ratios
// ----------------------------------------
`define SPICS_DIV16 16
`define SPICS_DIV64 64

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define SPICS_IRQ_DONE 0
`define SPICS_IRQ_WRITE_COLLISION_FLAG 1
`define SPICS_IRQ_OVF 2

`endif

// >>> rtl/spics_pkg.sv
// ----------------------------------------
// Shared types
// ----------------------------------------
package spics_pkg;

    // Register selected by a bus address
    typedef enum logic [2:0] {
        SPICS_R_CTRL,
        SPICS_R_BUF,
        SPICS_R_STAT,
        SPICS_R_CLR,
        SPICS_R_IEN,
        SPICS_R_GPIO,
        SPICS_R_NONE
    } spics_reg_e;

    // Four-bit mode field
    typedef logic [3:0] spics_mode_t;

endpackage

// >>> rtl/spics_shift.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Eight-bit shift engine, MSB first
// ----------------------------------------
module spics_shift
    import spics_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic load,
    input wire logic [7:0] load_data,
    input wire logic sample_en,
    input wire logic shift_en,
    input wire logic sdi,
    output logic sdo,
    output logic mid_byte,
    output logic done,
    output logic [7:0] rx_byte
);

    logic [7:0] sr; // Serial shift register
    logic rbit; // Bit caught on the sampling edge
    logic [2:0] cnt; // Bits shifted so far
    logic started; // A byte has begun

    // Last bit completes on the eighth shift edge
    assign done = run && shift_en && (cnt == 3'd7);
    assign rx_byte = {sr[6:0], rbit};
    assign sdo = sr[7];
    assign mid_byte = started;

    // Shift register: a load wins over a shift
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sr <= 8'h00;
        else if (load)
            sr <= load_data;
        else if (run && shift_en)
            sr <= {sr[6:0], rbit};
    end

    // Sample the input line
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rbit <= 1'b0;
        else if (run && sample_en)
            rbit <= sdi;
    end

    // Bit count restarts whenever the engine is stopped
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run)
            cnt <= 3'd0;
        else if (shift_en)
            cnt <= cnt + 3'd1;
    end

    // Byte in progress, seen as busy for collisions
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run || done)
            started <= 1'b0;
        else if (sample_en)
            started <= 1'b1;
    end

endmodule
`default_nettype wire

// >>> tb/spics_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// External master on the serial pins
// ----------------------------------------
module spics_peer (
    input wire logic aclk,
    input wire logic clock_idle_polarity,
    output logic sck,
    output logic sdi,
    output logic ss_n
);
    logic lvl; // Clock away from idle
    initial
    begin
        lvl = 1'b0;
        sdi = 1'b0;
        ss_n = 1'b1;
    end
    // Clock stands still at its idle level between frames
    assign sck = clock_idle_polarity ^ lvl;
    // One byte MSB first, eight aclk per half period
    task send(input logic [7:0] b, input logic sel);
        int i;
        @(posedge aclk);
        ss_n <= !sel;
        for (i = 7; i >= 0; i--)
        begin
            sdi <= b[i];
            repeat (8) @(posedge aclk);
            lvl <= 1'b1;
            repeat (8) @(posedge aclk);
            lvl <= 1'b0;
        end
        repeat (8) @(posedge aclk);
        // Released data shows the inverse so no stale bit is trusted
        ss_n <= 1'b1;
        sdi <= ~sdi;
    endtask
endmodule
`default_nettype wire

// >>> tb/spi_port_control_status_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "spics_defs.svh"
// ----------------------------------------
// Bench for the serial port control block
// ----------------------------------------
module spi_port_control_status_test;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, timer_two_pulse;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid, irq, clock_idle_polarity;
    logic [1:0] bresp, rresp, r;
    logic sck_o, sck_oe, sdo_o, sdo_oe, sdi_o, sdi_oe, ss_n_o, ss_n_oe;
    logic p_sck, p_sdi, p_ss_n; // Peer drive levels
    logic [2:0] tcnt; // Timer pulse every fifth cycle
    int n_mismatch, check_count;

    // Pins resolve from the device enables, else the peer; an undriven sdo pin reads back ~sdo_o
    spics_top spics_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .timer_two_pulse(timer_two_pulse), .sck_i(sck_oe ? sck_o : p_sck),
        .sck_o(sck_o), .sck_oe(sck_oe), .sdo_i(sdo_oe ? sdo_o : ~sdo_o),
        .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sdi_i(sdi_oe ? sdi_o : p_sdi),
        .sdi_o(sdi_o), .sdi_oe(sdi_oe), .ss_n_i(ss_n_oe ? ss_n_o : p_ss_n),
        .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe), .irq(irq));
    spics_peer spics_peer_i (.aclk(aclk), .clock_idle_polarity(clock_idle_polarity), .sck(p_sck), .sdi(p_sdi), .ss_n(p_ss_n));

    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // Free-running timer source
    always @(posedge aclk)
    begin
        tcnt <= (tcnt == 3'h4) ? 3'h0 : tcnt + 3'h1;
        timer_two_pulse <= (tcnt == 3'h4);
    end

    task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    task end_of_test;
        if (n_mismatch == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task hang(input string what);
        n_mismatch++;
        $display("CHECK FAILED %s exp answer got timeout", what);
        end_of_test;
    endtask
    // Bus write; handshakes sampled at the settled low phase
    task wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        logic ta, tw, tr;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tr = 1'b0;
        for (n = 0; n < 50 && !tr; n++)
        begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tr = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tr) bready <= 1'b0;
        end
        if (!tr) hang("write");
        @(negedge aclk);
    endtask
    task rd(input logic [7:0] a);
        int n;
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tr = 1'b0;
        for (n = 0; n < 50 && !tr; n++)
        begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
        end
        if (!tr) hang("read");
        @(negedge aclk);
    endtask
    // Count cycles until the clock pin reaches a level
    task wait_sck(input logic lvl, output int c);
        for (c = 0; c < 400; c++)
        begin
            @(negedge aclk);
            if (sck_o === lvl) break;
        end
        if (c == 400) hang("sck");
    endtask

    task reset_check;
        rd(`SPICS_CTRL_OFS);
        chk("ctrl reset", d, 32'h0);
        chk("pins gpio", {sck_oe, sdo_oe, sdi_oe, ss_n_oe}, 4'h0);
        rd(8'h40);
        chk("unmapped read", r, 2'b10);
        wr(8'h40, 32'h0);
        chk("unmapped write", r, 2'b10);
        chk("irq idle", irq, 1'b0);
    endtask
    // Master byte: rate, collision, no overflow
    task master(input logic [3:0] m, input logic k, input int half);
        int c;
        wr(`SPICS_CTRL_OFS, {26'h0, 1'b1, k, m});
        chk("idle level", sck_o, k);
        chk("pins taken", {sck_oe, sdo_oe, sdi_oe}, 3'b110);
        wr(`SPICS_BUF_OFS, 32'ha5);
        wait_sck(!k, c);
        wait_sck(k, c);
        chk("half period", c + 1, half);
        wr(`SPICS_BUF_OFS, 32'h5a);
        rd(`SPICS_CTRL_OFS);
        chk("collision", d[7], 1'b1);
        d = 32'h0;
        for (c = 0; c < 400 && d[0] !== 1'b1; c++) rd(`SPICS_STAT_OFS);
        if (c == 400) hang("done");
        chk("back idle", sck_o, k);
        rd(`SPICS_CTRL_OFS);
        chk("master overflow", d[6], 1'b0);
        wr(`SPICS_CLR_OFS, 32'h7);
        wr(`SPICS_CTRL_OFS, {26'h0, 1'b1, k, m});
        rd(`SPICS_CTRL_OFS);
        chk("collision clear", d[7], 1'b0);
    endtask
    // Slave without select; overflow and interrupt
    task slave_free;
        // Master bytes left the buffer full; the idle data line shifted in zeros
        rd(`SPICS_BUF_OFS);
        chk("master rx", d, 32'h0);
        wr(`SPICS_CTRL_OFS, 32'h25);
        wr(`SPICS_GPIO_OFS, 32'h88);
        chk("select free", {sck_oe, ss_n_oe, ss_n_o}, 3'b011);
        spics_peer_i.send(8'h3c, 1'b0);
        rd(`SPICS_BUF_OFS);
        chk("slave byte", d, 32'h3c);
        spics_peer_i.send(8'h96, 1'b0);
        rd(`SPICS_CTRL_OFS);
        chk("read in time", d[6], 1'b0);
        spics_peer_i.send(8'h11, 1'b0);
        rd(`SPICS_CTRL_OFS);
        chk("overflow", d[6], 1'b1);
        rd(`SPICS_BUF_OFS);
        chk("buffer kept", d, 32'h96);
        wr(`SPICS_IEN_OFS, 32'h4);
        chk("irq raised", irq, 1'b1);
        wr(`SPICS_IEN_OFS, 32'h0);
        chk("irq masked", irq, 1'b0);
        wr(`SPICS_IEN_OFS, 32'h4);
        wr(`SPICS_CLR_OFS, 32'h4);
        chk("irq cleared", irq, 1'b0);
        wr(`SPICS_CTRL_OFS, 32'h25);
        rd(`SPICS_CTRL_OFS);
        chk("overflow clear", d[6], 1'b0);
    endtask
    // Slave gated by the select pin
    task slave_sel;
        wr(`SPICS_CTRL_OFS, 32'h24);
        wr(`SPICS_CLR_OFS, 32'h7);
        chk("select input", ss_n_oe, 1'b0);
        spics_peer_i.send(8'hc3, 1'b0);
        rd(`SPICS_STAT_OFS);
        chk("deselected", d[0], 1'b0);
        spics_peer_i.send(8'hc3, 1'b1);
        rd(`SPICS_BUF_OFS);
        chk("selected", d, 32'hc3);
        wr(`SPICS_CTRL_OFS, 32'h0);
        wr(`SPICS_GPIO_OFS, 32'hf5);
        chk("pins back", {ss_n_oe, sdi_oe, sdo_oe, sck_oe, ss_n_o, sdi_o, sdo_o, sck_o}, 8'hf5);
    endtask

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, clock_idle_polarity} = 7'h0;
        {awaddr, araddr, wdata, tcnt, timer_two_pulse} = '0;
        wstrb = 4'hf;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        reset_check;
        master(4'h1, 1'b0, 8);
        master(4'h2, 1'b1, 32);
        master(4'h3, 1'b0, 5);
        slave_free;
        slave_sel;
        end_of_test;
    end
endmodule
`default_nettype wire
